// ==== rtl/pdtx_framer.sv ====
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Fifo mode appends each queue byte written while idle and not full, in arrival order.
// - Fifo mode takes writes at any queue offset; holds 74 entries.
// - Fifo mode queue reads return zero, never stored contents.
// - Reset clears fifo mode select; queue then acts as addressed buffer.
// - Buffer mode: lowest offset sent first, highest last, 74 locations.
// - Buffer mode allows any-order write and read-back of locations.
// - Automatic processing treats every queue entry as a whole message byte.
// - Message length register decides after which byte CRC is appended.
// - Automatic processing adds preamble, start ordered set and end symbol.
// - Raw processing takes full packet from queue; device adds preamble and CRC.
// - Raw entry with bit 5 clear: low nibble into CRC and encoded.
// - Nibble to five-bit symbol follows the fixed sixteen entry table.
// - Raw entry with bit 5 set: low five bits sent as is, no CRC.
// - Raw byte FF sends the accumulated CRC.
// - Raw byte FE halts transmission at once.
// - Any five-bit value passes with bit 5 set.
// - Datapath has CRC, encoder, serializer, preamble and programmable bit timer.
// - Control originates GoodCRC and BIST error messages; start type is fixed (three SYNC1, then SYNC2).
// - Go is only taken while line clear flag is set.
// - Raw processing ignores message length; ends only on stop code.
module pdtx_framer #(
  parameter int DEPTH = pdtx_pkg::QUEUE_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [15:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  input wire logic lineClear,
  input wire logic gcrcReq,
  input wire logic [2:0] gcrcMsgId,
  input wire logic bistReq,
  input wire logic [15:0] bistErrCount,
  output logic txBit,
  output logic txActive,
  output logic txDone
);
  import pdtx_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_PRE, ST_SOP, ST_DATA, ST_CRC, ST_EOP, ST_END} pdtx_state_t;

  logic [7:0] queueMem [DEPTH];
  logic [7:0] ctlFirst_ff, msgLen_ff, bitTime_ff, preLen_ff;
  logic [6:0] wrPtr_ff;
  logic busy_ff, done_ff, bit_ff;
  pdtx_state_t state_ff, nxt_state;
  logic [6:0] rdIdx_ff;
  logic hiNib_ff;
  logic [2:0] symCnt_ff;
  logic [7:0] preCnt_ff;
  logic [3:0] crcNib_ff;
  logic [31:0] crc_ff;
  logic [4:0] sym_ff;
  logic [2:0] bitIdx_ff;
  logic [7:0] timer_ff;
  logic [2:0] src_ff;
  logic [7:0] autoMsg [6];
  logic isFifo, isRaw, inQueue, queueIdxOk, fifoFull, qWrite, bitTick, symDone;
  logic goReq, startFw, startAuto, symLoad;
  logic [6:0] qIdx;
  logic [7:0] curByte;
  logic [3:0] curNib;
  logic [4:0] encSym;
  logic [31:0] crcNext;
  logic [7:0] lastIdx;
  logic rawFw, dataLoad;
  logic [2:0] crcSel;

  function automatic logic [4:0] enc4b5b(input logic [3:0] n);
    logic [4:0] s;
    s = 5'h1e;
    case (n)
      4'h0: s = 5'h1e;
      4'h1: s = 5'h09;
      4'h2: s = 5'h14;
      4'h3: s = 5'h15;
      4'h4: s = 5'h0a;
      4'h5: s = 5'h0b;
      4'h6: s = 5'h0e;
      4'h7: s = 5'h0f;
      4'h8: s = 5'h12;
      4'h9: s = 5'h13;
      4'ha: s = 5'h16;
      4'hb: s = 5'h17;
      4'hc: s = 5'h1a;
      4'hd: s = 5'h1b;
      4'he: s = 5'h1c;
      default: s = 5'h1d;
    endcase
    return s;
  endfunction

  function automatic logic [31:0] crcStep(input logic [31:0] c, input logic [3:0] n);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 4; i++) begin
      r = (r[31] ^ n[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  assign isFifo = ctlFirst_ff[FIFO_MODE_BIT];
  assign isRaw = ctlFirst_ff[RAW_MODE_BIT];
  assign inQueue = (regAddr >= TXQ_BASE) && (regAddr <= TXQ_LAST);
  assign qIdx = 7'(regAddr - TXQ_BASE);
  assign queueIdxOk = 32'(qIdx) < DEPTH;
  assign fifoFull = 32'(wrPtr_ff) >= DEPTH;
  // Fifo: any queue offset is the next entry; full drops the write
  assign qWrite = regWrite && inQueue && queueIdxOk && !busy_ff && !(isFifo && fifoFull);
  assign goReq = regWrite && (regAddr == CTL_SECOND_ADDR) && regWrData[GO_BIT];
  assign startFw = goReq && lineClear && !busy_ff;
  assign startAuto = !busy_ff && !goReq && (gcrcReq || bistReq);
  assign bitTick = busy_ff && (timer_ff == 8'h00);
  assign symDone = bitTick && (bitIdx_ff == 3'd4);
  assign curByte = (src_ff == SRC_FW) ? queueMem[rdIdx_ff] : autoMsg[rdIdx_ff[2:0]];
  assign curNib = hiNib_ff ? curByte[7:4] : curByte[3:0];
  assign encSym = enc4b5b(isRaw && src_ff == SRC_FW ? curByte[3:0] : curNib);
  assign crcNext = crcStep(crc_ff, isRaw && src_ff == SRC_FW ? curByte[3:0] : curNib);
  assign lastIdx = (src_ff == SRC_FW) ? msgLen_ff - 8'h01 : ((src_ff == SRC_BIST) ? 8'h05 : 8'h01);
  assign symLoad = symDone || (state_ff == ST_PRE && bitTick && preCnt_ff == 8'h01);
  assign rawFw = isRaw && (src_ff == SRC_FW);
  // A data symbol is loaded here; the pointer then moves to the entry sent next
  assign dataLoad = symLoad && (nxt_state == ST_DATA);
  // First CRC nibble on entry, then the one after the nibble now going out
  assign crcSel = (state_ff == ST_CRC) ? crcNib_ff[2:0] + 3'h1 : 3'h0;

  // Automatic responses: two header bytes, BIST adds one data object
  assign autoMsg[0] = {(src_ff == SRC_BIST) ? BISTERR_TYPE : GOODCRC_TYPE, 4'h0};
  assign autoMsg[1] = {(src_ff == SRC_BIST) ? 4'h1 : 4'h0, gcrcMsgId, 1'b0};
  assign autoMsg[2] = bistErrCount[7:0];
  assign autoMsg[3] = bistErrCount[15:8];
  assign autoMsg[4] = 8'h00;
  assign autoMsg[5] = 8'h50;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctlFirst_ff <= 8'h00;
      msgLen_ff <= 8'h00;
      bitTime_ff <= BIT_TIME_RST;
      preLen_ff <= PREAMBLE_RST;
    end else if (regWrite) begin
      case (regAddr)
        CTL_FIRST_ADDR: ctlFirst_ff <= regWrData;
        MSG_LEN_ADDR: msgLen_ff <= regWrData;
        BIT_TIME_ADDR: bitTime_ff <= regWrData;
        PREAMBLE_ADDR: preLen_ff <= regWrData;
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wrPtr_ff <= 7'h00;
    end else if (regWrite && regAddr == CTL_SECOND_ADDR && regWrData[RST_WRPTR_BIT]) begin
      wrPtr_ff <= 7'h00;
    end else if (qWrite && isFifo) begin
      wrPtr_ff <= wrPtr_ff + 7'h01;
    end
  end

  // Buffer mode addresses the location, fifo mode takes the next entry
  always_ff @(posedge core_clk) begin
    if (qWrite) begin
      queueMem[isFifo ? wrPtr_ff : qIdx] <= regWrData;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      regRdData <= 8'h00;
    end else if (regRead) begin
      if (inQueue) begin
        regRdData <= (isFifo || !queueIdxOk) ? 8'h00 : queueMem[qIdx];
      end else begin
        case (regAddr)
          CTL_FIRST_ADDR: regRdData <= ctlFirst_ff;
          CTL_SECOND_ADDR: regRdData <= {5'h00, lineClear, 1'b0, busy_ff};
          MSG_LEN_ADDR: regRdData <= msgLen_ff;
          BIT_TIME_ADDR: regRdData <= bitTime_ff;
          PREAMBLE_ADDR: regRdData <= preLen_ff;
          STATUS_ADDR: regRdData <= {6'h00, fifoFull, busy_ff};
          default: regRdData <= 8'h00;
        endcase
      end
    end
  end

  // Next state on symbol boundaries
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: nxt_state = ST_IDLE;
      ST_PRE: if (bitTick && preCnt_ff == 8'h01) nxt_state = (isRaw && src_ff == SRC_FW) ? ST_DATA : ST_SOP;
      ST_SOP: if (symDone && symCnt_ff == 3'd3) nxt_state = ST_DATA;
      ST_DATA: begin
        // The pointer already names the next entry, so codes act at a symbol end
        if (rawFw) begin
          if (symDone && curByte == CODE_STOP) nxt_state = ST_END;
          else if (symDone && curByte == CODE_INS_CRC) nxt_state = ST_CRC;
        end else if (symDone && !hiNib_ff && {1'b0, rdIdx_ff} == lastIdx + 8'h01) begin
          nxt_state = ST_CRC;
        end
      end
      ST_CRC: if (symDone && crcNib_ff == 4'h7) nxt_state = (isRaw && src_ff == SRC_FW) ? ST_DATA : ST_EOP;
      ST_EOP: if (symDone) nxt_state = ST_END;
      // Wait one bit time so the last bit stands as long as the others
      ST_END: if (bitTick) nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      src_ff <= SRC_FW;
      rdIdx_ff <= 7'h00;
      hiNib_ff <= 1'b0;
      symCnt_ff <= 3'h0;
      crcNib_ff <= 4'h0;
      preCnt_ff <= 8'h00;
      crc_ff <= CRC_INIT;
    end else begin
      state_ff <= nxt_state;
      done_ff <= (state_ff == ST_END) && bitTick;
      if (state_ff == ST_END && bitTick) busy_ff <= 1'b0;
      if (startFw || startAuto) begin
        busy_ff <= 1'b1;
        state_ff <= ST_PRE;
        src_ff <= startFw ? SRC_FW : (gcrcReq ? SRC_GCRC : SRC_BIST);
        rdIdx_ff <= 7'h00;
        hiNib_ff <= 1'b0;
        symCnt_ff <= 3'h0;
        crcNib_ff <= 4'h0;
        preCnt_ff <= preLen_ff;
        crc_ff <= CRC_INIT;
      end
      if (state_ff == ST_PRE && bitTick) preCnt_ff <= preCnt_ff - 8'h01;
      if (state_ff == ST_SOP && symDone) symCnt_ff <= symCnt_ff + 3'h1;
      if (state_ff == ST_CRC && symDone) crcNib_ff <= crcNib_ff + 4'h1;
      // Step over the insert code so the entry after it follows the CRC
      if (state_ff == ST_DATA && rawFw && symDone && curByte == CODE_INS_CRC) begin
        rdIdx_ff <= rdIdx_ff + 7'h01;
      end
      // Pointer and CRC move as a symbol is loaded, so no entry goes out twice
      if (dataLoad) begin
        if (rawFw) begin
          if (!curByte[CTRL_FLAG_BIT]) crc_ff <= crcNext;
          rdIdx_ff <= (32'(rdIdx_ff) == DEPTH - 1) ? 7'h00 : rdIdx_ff + 7'h01;
        end else begin
          crc_ff <= crcNext;
          hiNib_ff <= !hiNib_ff;
          if (hiNib_ff) rdIdx_ff <= rdIdx_ff + 7'h01;
        end
      end
    end
  end

  // Symbol choice for the next five bits
  logic [4:0] nxtSym;
  logic [31:0] crcOut;
  assign crcOut = ~{<<{crc_ff}};
  always_comb begin
    nxtSym = SYM_SYNC1;
    case (nxt_state)
      ST_SOP: nxtSym = (symCnt_ff == 3'd3 || (state_ff == ST_SOP && symCnt_ff == 3'd2)) ? SYM_SYNC2 : SYM_SYNC1;
      ST_DATA: nxtSym = (isRaw && src_ff == SRC_FW && curByte[CTRL_FLAG_BIT]) ? curByte[4:0] : encSym;
      ST_CRC: nxtSym = enc4b5b(crcOut[4 * crcSel +: 4]);
      ST_EOP: nxtSym = SYM_EOP;
      default: nxtSym = SYM_SYNC1;
    endcase
  end

  // Bit timer and serializer: preamble alternates, symbols go LSB first
  always_ff @(posedge core_clk) begin
    if (rst) begin
      timer_ff <= 8'h00;
      bitIdx_ff <= 3'h0;
      sym_ff <= 5'h00;
      bit_ff <= 1'b0;
    end else if (!busy_ff) begin
      timer_ff <= bitTime_ff;
      bitIdx_ff <= 3'h0;
      bit_ff <= 1'b0;
    end else if (bitTick && state_ff != ST_END) begin
      timer_ff <= bitTime_ff;
      if (state_ff == ST_PRE) begin
        bit_ff <= preCnt_ff[0];
        if (preCnt_ff == 8'h01) sym_ff <= nxtSym;
      end else begin
        bitIdx_ff <= symDone ? 3'h0 : bitIdx_ff + 3'h1;
        bit_ff <= sym_ff[bitIdx_ff];
        if (symDone) sym_ff <= nxtSym;
      end
    end else begin
      timer_ff <= timer_ff - 8'h01;
    end
  end

  assign txBit = bit_ff;
  assign txActive = busy_ff;
  assign txDone = done_ff;

  a_go_needs_clear: assert property (
    @(posedge core_clk) disable iff (rst)
    (!busy_ff && !lineClear && !gcrcReq && !bistReq) |=> !busy_ff) else $error("started without line clear");

  a_go_starts: assert property (
    @(posedge core_clk) disable iff (rst)
    startFw |=> (busy_ff && state_ff == ST_PRE)) else $error("accepted go did not start");

  a_fifo_full_hold: assert property (
    @(posedge core_clk) disable iff (rst)
    (isFifo && fifoFull && regWrite && inQueue) |=> $stable(wrPtr_ff)) else $error("full fifo advanced");

  a_fifo_append: assert property (
    @(posedge core_clk) disable iff (rst)
    (qWrite && isFifo) |=> wrPtr_ff == $past(wrPtr_ff) + 7'h01) else $error("fifo write not appended");

  a_buffer_keeps_ptr: assert property (
    @(posedge core_clk) disable iff (rst)
    (qWrite && !isFifo) |=> $stable(wrPtr_ff)) else $error("buffer write moved pointer");

  a_fifo_no_read: assert property (
    @(posedge core_clk) disable iff (rst)
    (regRead && inQueue && isFifo) |=> regRdData == 8'h00) else $error("fifo data read back");

  a_sop_then_data: assert property (
    @(posedge core_clk) disable iff (rst)
    (state_ff == ST_SOP && symDone && symCnt_ff == 3'd3) |=> state_ff == ST_DATA) else $error("start set too long");

  a_crc_after_len: assert property (
    @(posedge core_clk) disable iff (rst)
    (state_ff == ST_DATA && !rawFw && symDone && !hiNib_ff && {1'b0, rdIdx_ff} == lastIdx + 8'h01)
    |=> state_ff == ST_CRC) else $error("crc not after last byte");

  a_crc_eight_syms: assert property (
    @(posedge core_clk) disable iff (rst)
    (state_ff == ST_CRC && symDone && crcNib_ff == 4'h7) |=> state_ff != ST_CRC) else $error("crc too long");

  a_raw_ctrl_no_crc: assert property (
    @(posedge core_clk) disable iff (rst)
    (dataLoad && rawFw && curByte[CTRL_FLAG_BIT]) |=> $stable(crc_ff)) else $error("control entry in crc");

  a_raw_len_ignored: assert property (
    @(posedge core_clk) disable iff (rst)
    (state_ff == ST_DATA && rawFw && symDone && curByte != CODE_STOP && curByte != CODE_INS_CRC)
    |=> state_ff == ST_DATA) else $error("raw frame ended without stop");

  a_stop_halts: assert property (
    @(posedge core_clk) disable iff (rst)
    (state_ff == ST_DATA && rawFw && symDone && curByte == CODE_STOP) |=> state_ff == ST_END) else $error("stop code did not halt");
endmodule
`default_nettype wire

// ==== rtl/pdtx_pkg.sv ====
package pdtx_pkg;
  // Register byte offsets
  localparam logic [15:0] TXQ_BASE = 16'h1800;
  localparam logic [15:0] TXQ_LAST = 16'h1849;
  localparam logic [15:0] CTL_FIRST_ADDR = 16'h1850;
  localparam logic [15:0] CTL_SECOND_ADDR = 16'h1851;
  localparam logic [15:0] MSG_LEN_ADDR = 16'h1852;
  localparam logic [15:0] BIT_TIME_ADDR = 16'h1853;
  localparam logic [15:0] PREAMBLE_ADDR = 16'h1854;
  localparam logic [15:0] STATUS_ADDR = 16'h1855;
  localparam int QUEUE_DEPTH = 74;
  // Control first fields
  localparam int FIFO_MODE_BIT = 0;
  localparam int RAW_MODE_BIT = 1;
  localparam int SOP_TYPE_LSB = 2;
  // Control second fields
  localparam int GO_BIT = 0;
  localparam int RST_WRPTR_BIT = 1;
  localparam int LINE_CLEAR_BIT = 2;
  // Status fields
  localparam int BUSY_BIT = 0;
  localparam int FULL_BIT = 1;
  // Raw-mode codes, line symbols and CRC constants
  localparam logic [7:0] CODE_INS_CRC = 8'hff;
  localparam logic [7:0] CODE_STOP = 8'hfe;
  localparam int CTRL_FLAG_BIT = 5;
  localparam logic [4:0] SYM_SYNC1 = 5'h18;
  localparam logic [4:0] SYM_SYNC2 = 5'h11;
  localparam logic [4:0] SYM_SYNC3 = 5'h06;
  localparam logic [4:0] SYM_EOP = 5'h0d;
  localparam logic [31:0] CRC_POLY = 32'h04c11db7;
  localparam logic [31:0] CRC_INIT = 32'hffffffff;
  // Reset values, message types and frame sources
  localparam logic [7:0] BIT_TIME_RST = 8'h32;
  localparam logic [7:0] PREAMBLE_RST = 8'h40;
  localparam logic [3:0] GOODCRC_TYPE = 4'h1;
  localparam logic [3:0] BISTERR_TYPE = 4'h3;
  localparam logic [2:0] SRC_FW = 3'h0;
  localparam logic [2:0] SRC_GCRC = 3'h1;
  localparam logic [2:0] SRC_BIST = 3'h2;
endpackage

// ==== tb/pdtx_bmc_sink.sv ====
`timescale 1ns/100ps
`default_nettype none
// Stands in for the BMC encoder: it keeps one sample of the line per clock while a frame is on.
// Sampling every clock, not once per bit, means the bench can check the bit timer as well.
module pdtx_bmc_sink (
  input wire logic core_clk,
  input wire logic txBit,
  input wire logic txActive
);
  logic bits[$];
  always @(posedge core_clk) begin
    if (txActive === 1'b1) begin
      bits.push_back(txBit);
    end
  end
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb;
  import pdtx_pkg::*;
  logic core_clk = 1'b0, rst = 1'b1, regWrite = 1'b0, regRead = 1'b0, lineClear = 1'b0;
  logic gcrcReq = 1'b0, bistReq = 1'b0, txBit, txActive, txDone;
  logic [15:0] regAddr = 16'h0000, bistErrCount = 16'h0003;
  logic [7:0] regWrData = 8'h00, regRdData, rd8;
  logic [2:0] gcrcMsgId = 3'h0;
  int numErrors = 0, comparisons = 0;
  logic [4:0] enc[16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
                          5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
  logic [4:0] sop[$] = '{SYM_SYNC1, SYM_SYNC1, SYM_SYNC1, SYM_SYNC2};
  always #10 core_clk = ~core_clk;
  pdtx_framer #(.DEPTH(QUEUE_DEPTH)) i_dut (.core_clk(core_clk), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .lineClear(lineClear), .gcrcReq(gcrcReq), .gcrcMsgId(gcrcMsgId), .bistReq(bistReq),
    .bistErrCount(bistErrCount), .txBit(txBit), .txActive(txActive), .txDone(txDone));
  pdtx_bmc_sink i_sink (.core_clk(core_clk), .txBit(txBit), .txActive(txActive));

  task automatic endOfTest;
    $display("comparisons %0d mismatches %0d", comparisons, numErrors);
    if (numErrors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      numErrors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  task automatic chkInt(input int got, input int exp, input string m);
    comparisons++;
    if (got != exp) begin
      numErrors++;
      $display("mismatch at %0t: %s got %0d expected %0d", $time, m, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge core_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    @(negedge core_clk);
    rd8 = regRdData;
  endtask
  // Bit time is programmed to two clocks, so every symbol bit shows as two samples, LSB first
  function automatic int find(input logic [4:0] s[$], input int from);
    logic p[$];
    int ok;
    foreach (s[k]) for (int b = 0; b < 5; b++) repeat (2) p.push_back(s[k][b]);
    for (int i = from; i + p.size() <= i_sink.bits.size(); i++) begin
      ok = 1;
      foreach (p[j]) if (i_sink.bits[i + j] !== p[j]) ok = 0;
      if (ok == 1) return i + p.size();
    end
    return -1;
  endfunction
  task automatic waitFrame(input string m);
    int n;
    logic seen;
    n = 0;
    seen = 1'b0;
    while (txActive !== 1'b1 && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    while (txActive === 1'b1 && n < 4000) begin
      @(negedge core_clk);
      n++;
      seen |= (txDone === 1'b1);
    end
    repeat (3) begin
      @(negedge core_clk);
      seen |= (txDone === 1'b1);
    end
    chkInt(int'(seen), 1, {m, " completion pulse"});
  endtask
  // Body, then eight CRC symbols, then the end symbol and nothing after it
  task automatic chkFrame(input logic [4:0] pre[$], input string m);
    int i, e;
    i = find(pre, 0);
    chkInt(int'(i >= 0), 1, {m, " body"});
    chkInt(int'(i - 10 * pre.size() >= 16), 1, {m, " preamble ahead"});
    e = find('{SYM_EOP}, i + 80);
    chkInt(e, i + 90, {m, " crc then end symbol"});
    chkInt(int'(i_sink.bits.size() - e <= 6), 1, {m, " nothing after end"});
  endtask

  task automatic testBuffer;
    rd(CTL_FIRST_ADDR);
    chk8(rd8 & 8'h01, 8'h00, "fifo select after reset");
    wr(TXQ_LAST, 8'h5a);
    wr(TXQ_BASE, 8'ha5);
    rd(TXQ_LAST);
    chk8(rd8, 8'h5a, "last location");
    rd(TXQ_BASE);
    chk8(rd8, 8'ha5, "first location");
    $display("test buffer finished");
  endtask
  task automatic testFifoAuto;
    wr(CTL_FIRST_ADDR, 8'h01);
    wr(CTL_SECOND_ADDR, 8'h02);
    for (int k = 0; k < 75; k++) wr(TXQ_BASE + 16'(k % 10), 8'h80 + 8'(k));
    rd(STATUS_ADDR);
    chk8(rd8 & 8'h02, 8'h02, "fifo full");
    rd(TXQ_BASE);
    chk8(rd8, 8'h00, "fifo read hides data");
    wr(MSG_LEN_ADDR, 8'h02);
    wr(CTL_SECOND_ADDR, 8'h01);
    repeat (20) @(posedge core_clk);
    chk8({7'h00, txActive}, 8'h00, "go while line busy");
    lineClear <= 1'b1;
    i_sink.bits.delete();
    wr(CTL_SECOND_ADDR, 8'h01);
    waitFrame("auto");
    chkFrame({sop, enc[0], enc[8], enc[1], enc[8]}, "auto");
    wr(CTL_SECOND_ADDR, 8'h02);
    rd(STATUS_ADDR);
    chk8(rd8 & 8'h02, 8'h00, "full after pointer reset");
    $display("test fifo auto finished");
  endtask
  task automatic testRaw;
    logic [7:0] q[$];
    logic [4:0] ex[$];
    int e;
    wr(CTL_FIRST_ADDR, 8'h02);
    wr(MSG_LEN_ADDR, 8'h01);
    q = '{8'h38, 8'h38, 8'h38, 8'h31};
    ex = sop;
    for (int k = 0; k < 16; k++) begin
      q.push_back(8'(k));
      ex.push_back(enc[k]);
    end
    // Firmware framing codes, a reserved symbol, then crc insert, end and stop
    q = {q, 8'h20, 8'h27, 8'h39, 8'hff, 8'h2d, 8'hfe, 8'h25};
    ex = {ex, 5'h00, 5'h07, 5'h19};
    foreach (q[k]) wr(TXQ_BASE + 16'(k), q[k]);
    i_sink.bits.delete();
    wr(CTL_SECOND_ADDR, 8'h01);
    waitFrame("raw");
    chkFrame(ex, "raw");
    // Firmware's own check nibbles, no insert code: end symbol follows them directly
    q = '{8'h38, 8'h38, 8'h38, 8'h31, 8'h03, 8'h0c, 8'h2d, 8'hfe};
    foreach (q[k]) wr(TXQ_BASE + 16'(k), q[k]);
    i_sink.bits.delete();
    wr(CTL_SECOND_ADDR, 8'h01);
    waitFrame("raw own crc");
    e = find({sop, enc[3], enc[12], SYM_EOP}, 0);
    chkInt(int'(e > 0 && i_sink.bits.size() - e <= 6), 1, "raw own crc");
    $display("test raw finished");
  endtask
  task automatic testAutoReq;
    wr(CTL_FIRST_ADDR, 8'h00);
    i_sink.bits.delete();
    @(posedge core_clk);
    gcrcMsgId <= 3'h5;
    gcrcReq <= 1'b1;
    @(posedge core_clk);
    gcrcReq <= 1'b0;
    waitFrame("goodcrc");
    chkInt(int'(find(sop, 0) >= 0), 1, "goodcrc start");
    i_sink.bits.delete();
    @(posedge core_clk);
    bistReq <= 1'b1;
    @(posedge core_clk);
    bistReq <= 1'b0;
    waitFrame("bist");
    chkInt(int'(find(sop, 0) >= 0), 1, "bist start");
    $display("test auto requests finished");
  endtask

  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    wr(BIT_TIME_ADDR, 8'h01);
    wr(PREAMBLE_ADDR, 8'h08);
    testBuffer;
    testFifoAuto;
    testRaw;
    testAutoReq;
    endOfTest;
  end
  // All tests need well under ten thousand cycles
  initial begin
    repeat (60000) @(posedge core_clk);
    numErrors++;
    $display("mismatch at %0t: watchdog expired", $time);
    endOfTest;
  end
endmodule
`default_nettype wire
